//--- design/afm_pkg.sv
// constants for the all-frames mode tracker
// assumes one 125 MHz clock and an apb master for software
// Operation
// - first block info word never forwarded
// - address packet carries its vector word number
// - block info packets only when enabled
// - long address: word after vector is message
// - four phases at 6400, one at 1600
// - packets leave block by block, phase by phase
// - all-frames mode decodes every frame
// - end-of-frame status packet each frame in mode
// - mode entered by itself from counters
// - one fragment counter, sixteen address counters
// - vectors increment the matching counters
// - mode holds until counters zero, force clear
// - increments internal, decrements by host packet
// - counters cleared on reset and decoder off
// - fragment decrement bit lowers fragment counter
// - force bit enters all-frames mode
// - address decrement bits lower matching counters
// - address disabled when its counter is zero
// - command packet: id 03, flags, bits 15..0
package afm_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] CTRL_OFS  = 12'h000;
  localparam logic [11:0] STAT_OFS  = 12'h004;
  localparam logic [11:0] TAEN_OFS  = 12'h008;
  localparam logic [11:0] TACNT_OFS = 12'h040;
  localparam logic [11:0] TACNT_END = 12'h07C;
  localparam int CTRL_ON_BIT   = 0;
  localparam int CTRL_BIE_BIT  = 1;
  localparam int CTRL_RATE_LSB = 2;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // ****************************************
  // command packet layout
  // ****************************************
  localparam logic [7:0] CMD_ID   = 8'h03;
  localparam int CMD_BITS         = 32;
  localparam int CMD_DEC_FRAG_BIT = 23;
  localparam int CMD_FORCE_BIT    = 22;
  localparam int SYNC_STAGES      = 2;

  // ****************************************
  // counters
  // ****************************************
  localparam int NUM_TA = 16;
  localparam int CNT_W  = 7;
  localparam logic [CNT_W-1:0] CNT_MAX = 7'h7F;

  // ****************************************
  // codeword and packet codes
  // ****************************************
  typedef enum logic [1:0] {
    RATE_1600 = 2'h0,
    RATE_3200 = 2'h1,
    RATE_6400 = 2'h2
  } rate_t;

  typedef enum logic [2:0] {
    K_BIW1  = 3'h0,
    K_BIW   = 3'h1,
    K_ADDR  = 3'h2,
    K_LADDR = 3'h3,
    K_VECT  = 3'h4,
    K_MESS  = 3'h5
  } kind_t;

  typedef enum logic [2:0] {
    P_ADDR  = 3'h0,
    P_LADDR = 3'h1,
    P_VECT  = 3'h2,
    P_MESS  = 3'h3,
    P_BIW   = 3'h4,
    P_STAT  = 3'h5
  } ptype_t;

endpackage

//--- design/sat_counter.sv
// saturating up/down counter for one tracking count
// assumes increment and decrement are single-cycle pulses
`timescale 1ns/10ps
module sat_counter
  import afm_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_clear,
  input  wire logic             i_inc,
  input  wire logic             i_dec,
  output logic [CNT_W-1:0]      o_count
);

  // ****************************************
  // count
  // ****************************************
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_count <= '0;
    end else if (i_clear) begin
      o_count <= '0;
    end else begin
      unique case ({i_inc, i_dec})
        2'b10: if (o_count != CNT_MAX) o_count <= o_count + 7'h01;
        2'b01: if (o_count != '0) o_count <= o_count - 7'h01;
        default: o_count <= o_count;
      endcase
    end
  end

endmodule // sat_counter

//--- design/all_frames_mode_tracker.sv
// packet ordering and all-frames mode tracking
// assumes an apb master, a deinterleaver that hands over
// codewords block by block and phase by phase, and a
// host command link sampled on the reference clock
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/10ps
module all_frames_mode_tracker
  import afm_pkg::*;
(
  input  wire logic        I_REF_CLK,
  input  wire logic        I_NRST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic        I_LINK_SCLK,
  input  wire logic        I_LINK_MOSI,
  input  wire logic        I_LINK_SEL_N,
  input  wire logic        I_CW_VALID,
  input  wire logic [2:0]  I_CW_KIND,
  input  wire logic [1:0]  I_CW_PHASE,
  input  wire logic [6:0]  I_CW_WORD,
  input  wire logic [6:0]  I_CW_VEC_WORD,
  input  wire logic [20:0] I_CW_DATA,
  input  wire logic        I_VEC_LONG,
  input  wire logic        I_VEC_TA_SET,
  input  wire logic [3:0]  I_VEC_TA_IDX,
  input  wire logic        I_VEC_FRAG,
  input  wire logic        I_FRAME_END,
  input  wire logic [6:0]  I_FRAME_NUM,
  input  wire logic        I_PROG_FRAME,
  output logic             O_PKT_VALID,
  output logic      [2:0]  O_PKT_TYPE,
  output logic      [1:0]  O_PKT_PHASE,
  output logic      [6:0]  O_PKT_WORD,
  output logic      [20:0] O_PKT_DATA,
  output logic             O_DECODE_FRAME,
  output logic             O_ALL_FRAMES_MODE,
  output logic      [15:0] O_TA_ENABLE
);

  // ****************************************
  // declarations
  // ****************************************
  logic [3:0]             ctrl;
  logic                   decoder_on;
  logic                   block_info_enable;
  logic [1:0]             rate;
  logic                   force_every_frame;
  logic [CNT_W-1:0]       frag_cnt;
  logic [CNT_W-1:0]       ta_cnt [NUM_TA];
  logic [NUM_TA-1:0]      ta_inc;
  logic [NUM_TA-1:0]      temp_address_decrement;
  logic                   fragment_counter_decrement;
  logic                   frag_inc;
  logic                   all_frames_mode;
  logic [SYNC_STAGES-1:0] sclk_s;
  logic [SYNC_STAGES-1:0] mosi_s;
  logic [SYNC_STAGES-1:0] sel_s;
  logic                   sclk_q;
  logic [CMD_BITS-1:0]    shift;
  logic [4:0]             bit_cnt;
  logic                   cmd_stb;
  logic                   cmd_ok;
  logic                   phase_ok;
  logic                   cw_take;
  logic [3:0]             long_next;
  logic                   eof_pend;
  logic                   apb_wr;
  logic                   tacnt_hit;
  logic [3:0]             tacnt_idx;
  logic                   mapped;

  assign decoder_on        = ctrl[CTRL_ON_BIT];
  assign block_info_enable = ctrl[CTRL_BIE_BIT];
  assign rate              = ctrl[CTRL_RATE_LSB+:2];

  // ****************************************
  // apb slave
  // ****************************************
  assign apb_wr    = I_PSEL & I_PENABLE & I_PWRITE;
  assign tacnt_hit = (I_PADDR >= TACNT_OFS) && (I_PADDR <= TACNT_END)
                     && (I_PADDR[1:0] == 2'h0);
  assign tacnt_idx = I_PADDR[5:2];
  assign mapped    = tacnt_hit || I_PADDR == CTRL_OFS
                     || I_PADDR == STAT_OFS || I_PADDR == TAEN_OFS;
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl <= CTRL_RST;
    end else if (apb_wr && I_PADDR == CTRL_OFS) begin
      ctrl <= I_PWDATA[3:0];
    end
  end

  always_comb begin
    O_PRDATA = 32'h0000_0000;
    if (tacnt_hit) begin
      O_PRDATA = {25'h0, ta_cnt[tacnt_idx]};
    end else begin
      unique case (I_PADDR)
        CTRL_OFS: O_PRDATA = {28'h0, ctrl};
        STAT_OFS: O_PRDATA = {17'h0, frag_cnt, 6'h0,
                              force_every_frame, all_frames_mode};
        TAEN_OFS: O_PRDATA = {16'h0, O_TA_ENABLE};
        default:  O_PRDATA = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // host command link
  // ****************************************
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sclk_s <= '0;
      mosi_s <= '0;
      sel_s  <= '1;
      sclk_q <= 1'b0;
    end else begin
      sclk_s <= {sclk_s[0], I_LINK_SCLK};
      mosi_s <= {mosi_s[0], I_LINK_MOSI};
      sel_s  <= {sel_s[0], I_LINK_SEL_N};
      sclk_q <= sclk_s[1];
    end
  end

  // identifier byte first, msb first
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      shift   <= '0;
      bit_cnt <= '0;
      cmd_stb <= 1'b0;
    end else begin
      cmd_stb <= 1'b0;
      if (sel_s[1]) begin
        bit_cnt <= '0;
      end else if (sclk_s[1] && !sclk_q) begin
        shift   <= {shift[CMD_BITS-2:0], mosi_s[1]};
        bit_cnt <= bit_cnt + 5'h01;
        cmd_stb <= (bit_cnt == 5'h1F);
      end
    end
  end

  assign cmd_ok = cmd_stb && shift[31:24] == CMD_ID;
  assign fragment_counter_decrement =
    cmd_ok & shift[CMD_DEC_FRAG_BIT];
  assign temp_address_decrement =
    cmd_ok ? shift[15:0] : 16'h0000;

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      force_every_frame <= 1'b0;
    end else if (cmd_ok) begin
      force_every_frame <= shift[CMD_FORCE_BIT];
    end
  end

  // ****************************************
  // tracking counters
  // ****************************************
  assign frag_inc = cw_take && I_CW_KIND == K_VECT && I_VEC_FRAG;

  sat_counter u_frag (
    .i_clk   (I_REF_CLK),
    .i_nrst  (I_NRST),
    .i_clear (~decoder_on),
    .i_inc   (frag_inc),
    .i_dec   (fragment_counter_decrement),
    .o_count (frag_cnt)
  );

  generate
    for (genvar t = 0; t < NUM_TA; t++) begin : g_ta
      assign ta_inc[t] = cw_take && I_CW_KIND == K_VECT
                         && I_VEC_TA_SET
                         && I_VEC_TA_IDX == 4'(t);
      sat_counter u_ta (
        .i_clk   (I_REF_CLK),
        .i_nrst  (I_NRST),
        .i_clear (~decoder_on),
        .i_inc   (ta_inc[t]),
        .i_dec   (temp_address_decrement[t]),
        .o_count (ta_cnt[t])
      );
      assign O_TA_ENABLE[t] = ta_cnt[t] != '0;
    end
  endgenerate

  // ****************************************
  // mode
  // ****************************************
  assign all_frames_mode = force_every_frame || frag_cnt != '0
                           || O_TA_ENABLE != 16'h0000;
  assign O_ALL_FRAMES_MODE = all_frames_mode;
  assign O_DECODE_FRAME = decoder_on
                          && (all_frames_mode || I_PROG_FRAME);

  // ****************************************
  // packet ordering
  // ****************************************
  always_comb begin
    unique case (rate)
      RATE_6400: phase_ok = 1'b1;
      RATE_3200: phase_ok = I_CW_PHASE[0] == 1'b0;
      default:   phase_ok = I_CW_PHASE == 2'h0;
    endcase
  end

  assign cw_take = I_CW_VALID && phase_ok && decoder_on;

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      long_next <= '0;
    end else if (I_FRAME_END || !decoder_on) begin
      long_next <= '0;
    end else if (cw_take) begin
      long_next[I_CW_PHASE] <= I_CW_KIND == K_VECT
                               && I_VEC_LONG;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      eof_pend <= 1'b0;
    end else if (I_FRAME_END && all_frames_mode) begin
      eof_pend <= 1'b1;
    end else if (!cw_take) begin
      eof_pend <= 1'b0;
    end
  end

  // packets leave in codeword arrival order
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PKT_VALID <= 1'b0;
      O_PKT_TYPE  <= 3'h0;
      O_PKT_PHASE <= 2'h0;
      O_PKT_WORD  <= 7'h00;
      O_PKT_DATA  <= 21'h00000;
    end else begin
      O_PKT_VALID <= 1'b0;
      O_PKT_PHASE <= I_CW_PHASE;
      O_PKT_WORD  <= I_CW_WORD;
      O_PKT_DATA  <= I_CW_DATA;
      if (cw_take) begin
        if (long_next[I_CW_PHASE]) begin
          O_PKT_VALID <= 1'b1;
          O_PKT_TYPE  <= P_MESS;
        end else begin
          unique case (I_CW_KIND)
            K_BIW1: O_PKT_VALID <= 1'b0;
            K_BIW: begin
              O_PKT_VALID <= block_info_enable;
              O_PKT_TYPE  <= P_BIW;
            end
            K_ADDR, K_LADDR: begin
              O_PKT_VALID <= 1'b1;
              O_PKT_TYPE  <= I_CW_KIND == K_ADDR ? P_ADDR : P_LADDR;
              O_PKT_WORD  <= I_CW_VEC_WORD;
            end
            K_VECT: begin
              O_PKT_VALID <= 1'b1;
              O_PKT_TYPE  <= P_VECT;
            end
            K_MESS: begin
              O_PKT_VALID <= 1'b1;
              O_PKT_TYPE  <= P_MESS;
            end
            default: O_PKT_VALID <= 1'b0;
          endcase
        end
      end else if (eof_pend) begin
        O_PKT_VALID <= 1'b1;
        O_PKT_TYPE  <= P_STAT;
        O_PKT_WORD  <= I_FRAME_NUM;
        O_PKT_DATA  <= 21'h00001;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);

  sequence s_long_vec;
    cw_take && I_CW_KIND == K_VECT && I_VEC_LONG && !I_FRAME_END;
  endsequence
  sequence s_same_phase_cw;
    cw_take && I_CW_PHASE == $past(I_CW_PHASE, 2);
  endsequence

  property p_no_biw1;
    cw_take && I_CW_KIND == K_BIW1 && !long_next[I_CW_PHASE]
      |=> !O_PKT_VALID;
  endproperty
  a_no_biw1: assert property (p_no_biw1)
    else $error("first block info word forwarded");

  property p_addr_word;
    cw_take && I_CW_KIND == K_ADDR && !long_next[I_CW_PHASE]
      |=> O_PKT_VALID && O_PKT_WORD == $past(I_CW_VEC_WORD);
  endproperty
  a_addr_word: assert property (p_addr_word)
    else $error("address packet word number wrong");

  property p_biw_gate;
    O_PKT_VALID && O_PKT_TYPE == P_BIW |-> $past(block_info_enable);
  endproperty
  a_biw_gate: assert property (p_biw_gate)
    else $error("block info packet sent while disabled");

  property p_long_msg;
    s_long_vec ##1 (!cw_take && !I_FRAME_END) ##1 s_same_phase_cw
      |=> O_PKT_VALID && O_PKT_TYPE == P_MESS;
  endproperty
  a_long_msg: assert property (p_long_msg)
    else $error("word after long vector not a message");

  property p_phase;
    O_PKT_VALID && O_PKT_TYPE != P_STAT && $past(rate) == RATE_1600
      |-> O_PKT_PHASE == 2'h0;
  endproperty
  a_phase: assert property (p_phase)
    else $error("packet from inactive phase");

  property p_decode;
    decoder_on && all_frames_mode |-> O_DECODE_FRAME;
  endproperty
  a_decode: assert property (p_decode)
    else $error("frame skipped in all-frames mode");

  property p_eof;
    I_FRAME_END && all_frames_mode ##1 !cw_take
      |=> O_PKT_VALID && O_PKT_TYPE == P_STAT;
  endproperty
  a_eof: assert property (p_eof)
    else $error("missing end-of-frame status packet");

  property p_mode_exit;
    !force_every_frame && frag_cnt == '0 && O_TA_ENABLE == 16'h0000
      |-> !O_ALL_FRAMES_MODE;
  endproperty
  a_mode_exit: assert property (p_mode_exit)
    else $error("mode held with counters at zero");

  property p_sat;
    frag_cnt == CNT_MAX && frag_inc && decoder_on
      |=> frag_cnt == CNT_MAX;
  endproperty
  a_sat: assert property (p_sat)
    else $error("fragment counter wrapped");

  property p_clear;
    !decoder_on |=> frag_cnt == '0 && O_TA_ENABLE == 16'h0000;
  endproperty
  a_clear: assert property (p_clear)
    else $error("counters not cleared when decoder off");

  property p_dec;
    fragment_counter_decrement && !frag_inc && frag_cnt != '0
      && decoder_on |=> frag_cnt == $past(frag_cnt) - 7'h01;
  endproperty
  a_dec: assert property (p_dec)
    else $error("fragment decrement not applied");

  property p_force;
    cmd_ok && shift[CMD_FORCE_BIT] |=> O_ALL_FRAMES_MODE [*2];
  endproperty
  a_force: assert property (p_force)
    else $error("force bit did not enter mode");

endmodule // all_frames_mode_tracker

//--- dv/host_link_model.sv
// host side of the command link: sends four-byte command packets
// assumes the tracker samples the link on its own clock
`timescale 1ns/10ps
module host_link_model (
  output logic o_sclk,
  output logic o_mosi,
  output logic o_sel_n
);
  // ****************************************
  // packet sender, 64 ns link clock
  // ****************************************
  initial begin
    o_sclk  = 1'b0;
    o_mosi  = 1'b1;
    o_sel_n = 1'b1;
  end

  // msb first, id byte leads; clock still outside frames
  task automatic send(input logic [31:0] pkt);
    #3;
    o_sel_n = 1'b0;
    #64;
    for (int i = 31; i >= 0; i--) begin
      o_mosi = pkt[i];
      #32 o_sclk = 1'b1;
      #32 o_sclk = 1'b0;
    end
    #32 o_sel_n = 1'b1;
    o_mosi = ~o_mosi;
    #96;
  endtask
endmodule // host_link_model

//--- dv/all_frames_mode_tracker_tb.sv
// self-checking bench for the all-frames mode tracker
// assumes afm_pkg and host_link_model are compiled first
`timescale 1ns/10ps
module all_frames_mode_tracker_tb;
  import afm_pkg::*;
  typedef struct packed {
    logic [2:0] t; logic [1:0] p; logic [6:0] w; logic [20:0] d;
  } exp_t;
  logic clk, nrst, psel, pen, pwr, slverr, sclk, mosi, seln;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic        pready, pslverr, cwv, vl, vt, vf, fend, prog;
  logic [2:0]  kind, ptype;
  logic [1:0]  ph, pph;
  logic [6:0]  wd, vw, fnum, pw;
  logic [20:0] cd, pd;
  logic [3:0]  idx;
  logic        pv, dec, mode;
  logic [15:0] taen;
  int          bad_count, cmp_count;
  exp_t        q[$];
  exp_t        e;

  all_frames_mode_tracker all_frames_mode_tracker_inst (
    .I_REF_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_LINK_SCLK(sclk), .I_LINK_MOSI(mosi), .I_LINK_SEL_N(seln),
    .I_CW_VALID(cwv), .I_CW_KIND(kind), .I_CW_PHASE(ph), .I_CW_WORD(wd),
    .I_CW_VEC_WORD(vw), .I_CW_DATA(cd), .I_VEC_LONG(vl),
    .I_VEC_TA_SET(vt), .I_VEC_TA_IDX(idx), .I_VEC_FRAG(vf),
    .I_FRAME_END(fend), .I_FRAME_NUM(fnum), .I_PROG_FRAME(prog),
    .O_PKT_VALID(pv), .O_PKT_TYPE(ptype), .O_PKT_PHASE(pph),
    .O_PKT_WORD(pw), .O_PKT_DATA(pd), .O_DECODE_FRAME(dec),
    .O_ALL_FRAMES_MODE(mode), .O_TA_ENABLE(taen));
  host_link_model host_inst (.o_sclk(sclk), .o_mosi(mosi),
    .o_sel_n(seln));

  // ****************************************
  // clock, shared tasks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_v, exp);
  endtask

  // one codeword; expected packet noted when one is due
  task automatic cw(input logic [2:0] k, input logic [1:0] p,
                    input logic [6:0] w, input logic [2:0] lng_ta_fr,
                    input logic [2:0] t, input logic due);
    logic [6:0]  v;
    logic [20:0] d;
    v = 7'($urandom);
    d = 21'($urandom);
    @(posedge clk);
    cwv <= 1'b1; kind <= k; ph <= p; wd <= w; vw <= v; cd <= d;
    {vl, vt, vf} <= lng_ta_fr;
    if (due) q.push_back({t, p, (t <= P_LADDR) ? v : w, d});
    @(posedge clk);
    cwv <= 1'b0;
    {vl, vt, vf} <= 3'h0;
  endtask

  task automatic cmd(input logic [31:0] pkt);
    host_inst.send(pkt);
    idle(10);
  endtask

  // ****************************************
  // packet monitor
  // ****************************************
  always @(posedge clk) begin
    if (pv === 1'b1) begin
      if (q.size() == 0) chk({29'h0, ptype}, 32'hFF);
      else begin
        e = q.pop_front();
        chk({29'h0, ptype}, {29'h0, e.t});
        if (e.t != P_BIW) chk({25'h0, pw}, {25'h0, e.w});
        if (e.t != P_STAT) chk({9'h0, pph, pd}, {9'h0, e.p, e.d});
        else chk({11'h0, pd}, 32'h1);
      end
    end
  end

  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {nrst, psel, pen, pwr, paddr, pwdata, cwv, kind, ph, wd} = '0;
    {vw, cd, vl, vt, vf, idx, fend, fnum, prog} = '0;
    bad_count = 0;
    cmp_count = 0;
    void'($urandom(32'h8D0B));
    idle(4);
    nrst <= 1'b1;
    idle(4);
    rd(STAT_OFS, 32'h0);
    rd(TAEN_OFS, 32'h0);
    rd(12'h020, 32'h0);
    chk({31'h0, slverr}, 32'h1);
    apb(1'b1, CTRL_OFS, 32'h9);
    chk({31'h0, dec}, 32'h0);
    cw(K_BIW1, 2'h0, 7'h0, 3'h0, P_BIW, 1'b0);
    cw(K_BIW, 2'h2, 7'h1, 3'h0, P_BIW, 1'b0);
    cw(K_ADDR, 2'h3, 7'h5, 3'h0, P_ADDR, 1'b1);
    cw(K_LADDR, 2'h1, 7'h5, 3'h0, P_LADDR, 1'b1);
    cw(K_VECT, 2'h2, 7'h8, 3'h4, P_VECT, 1'b1);
    cw(K_VECT, 2'h2, 7'h9, 3'h0, P_MESS, 1'b1);
    apb(1'b1, CTRL_OFS, 32'hB);
    cw(K_BIW, 2'h1, 7'h2, 3'h0, P_BIW, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h1);
    for (int p = 0; p < 4; p++)
      cw(K_MESS, 2'(p), 7'h20, 3'h0, P_MESS, p == 0);
    apb(1'b1, CTRL_OFS, 32'h9);
    cw(K_VECT, 2'h3, 7'h30, 3'h1, P_VECT, 1'b1);
    rd(STAT_OFS, 32'h101);
    chk({30'h0, mode, dec}, 32'h3);
    @(posedge clk);
    fend <= 1'b1;
    fnum <= 7'($urandom);
    @(posedge clk);
    q.push_back({P_STAT, 2'h0, fnum, 21'h1});
    fend <= 1'b0;
    idx <= 4'($urandom);
    cw(K_VECT, 2'h0, 7'h31, 3'h2, P_VECT, 1'b1);
    rd(TAEN_OFS, 32'h1 << idx);
    chk({16'h0, taen}, 32'h1 << idx);
    rd(TACNT_OFS + {6'h0, idx, 2'h0}, 32'h1);
    cmd({8'h03, 8'h80, 16'h1 << idx});
    rd(STAT_OFS, 32'h0);
    chk({15'h0, taen, mode}, 32'h0);
    cmd({8'h05, 8'h40, 16'h0});
    chk({31'h0, mode}, 32'h0);
    cmd({8'h03, 8'h40, 16'h0});
    rd(STAT_OFS, 32'h3);
    cmd({8'h03, 8'h80, 16'hFFFF});
    rd(STAT_OFS, 32'h0);
    prog <= 1'b1;
    idle(1);
    chk({31'h0, dec}, 32'h1);
    prog <= 1'b0;
    idle(1);
    chk({31'h0, dec}, 32'h0);
    repeat (130) cw(K_VECT, 2'($urandom), 7'h40, 3'h1, P_VECT, 1'b1);
    rd(STAT_OFS, 32'h7F01);
    apb(1'b1, CTRL_OFS, 32'h0);
    idle(2);
    rd(STAT_OFS, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h9);
    cw(K_VECT, 2'h0, 7'h50, 3'h3, P_VECT, 1'b1);
    idle(1);
    nrst <= 1'b0;
    idle(1);
    chk({15'h0, taen, mode}, 32'h0);
    nrst <= 1'b1;
    idle(2);
    rd(STAT_OFS, 32'h0);
    rd(CTRL_OFS, 32'h0);
    chk(q.size(), 32'h0);
    report_and_stop();
  end
endmodule // all_frames_mode_tracker_tb
